// ==== design/sep_pkg.sv ====
// Shared constants for the two-wire serial EEPROM slave and its master.
// Assumes both ends run on one 125 MHz system clock.
package sep_pkg;
  localparam int          ADDR_W       = 14;
  localparam int          PAGE_W       = 6;
  localparam int          PAGE_BYTES   = 64;
  localparam logic [3:0]  DEV_CODE     = 4'ha;
  localparam int          CLK_NS       = 8;
  localparam int          WRITE_NS     = 5000000;
  localparam int          WRITE_CYC    = (WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          LINK_HALF_NS = 64;
  localparam int          LINK_HALF    = LINK_HALF_NS / CLK_NS;
  localparam int          MEM_WORDS    = 16384;
  typedef enum logic [1:0] {
    SEP_CMD_WRITE,
    SEP_CMD_READ_CUR,
    SEP_CMD_READ_RAND,
    SEP_CMD_POLL
  } sep_cmd_e;
endpackage : sep_pkg

// ==== design/sep_link_if.sv ====
// Two-wire link between the EEPROM slave and the bus master.
// Assumes open-drain lines with pull-ups; enables pull the wire low.
`timescale 1ns/1ns
`default_nettype none
interface sep_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  wire  scl = ~(scl_oe & ~scl_o);
  wire  sda = ~(sda_m_oe & ~sda_m_o) & ~(sda_s_oe & ~sda_s_o);
  modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport mst (input scl, input sda, output scl_o, output scl_oe,
               output sda_m_o, output sda_m_oe);
endinterface : sep_link_if
`default_nettype wire

// ==== design/sep_dev.sv ====
// Two-wire serial EEPROM slave: page write, ack polling, reads.
// Assumes link pins sampled on i_clk_sys; memory held in flip-flops.
`timescale 1ns/1ns
`default_nettype none
module sep_dev #(
  parameter int WRITE_CYC = sep_pkg::WRITE_CYC  // Write cycle length in clocks
) (
  input  wire logic       i_clk_sys,            // System clock
  input  wire logic       i_rst_n,              // Synchronous reset, active low
  input  wire logic [2:0] i_chip_select_inputs, // Chip select straps
  input  wire logic       i_wp,                 // Write protect, high protects
  sep_link_if.dev         link,                 // Two-wire link
  output logic            o_busy                // Write cycle in progress
);
  localparam int AW = sep_pkg::ADDR_W;
  localparam int PW = sep_pkg::PAGE_W;

  typedef enum logic [2:0] {
    SEP_IDLE, SEP_RX, SEP_RX_ACK, SEP_TX, SEP_TX_ACK
  } sep_dev_state_e;

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_d;
  logic       sda_d;
  logic [1:0] wp_sync;
  logic [2:0] cs_meta;
  logic [2:0] cs_sync;
  logic       scl_s;
  logic       sda_s;
  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];

  // Two flops per pin before any logic reads it
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      wp_sync  <= 2'h0;
      cs_meta  <= 3'h0;
      cs_sync  <= 3'h0;
    end else begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      scl_d    <= scl_s;
      sda_d    <= sda_s;
      wp_sync  <= {wp_sync[0], i_wp};
      cs_meta  <= i_chip_select_inputs;
      cs_sync  <= cs_meta;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

  logic [7:0]       mem [sep_pkg::MEM_WORDS];
  logic [7:0]       page_buf [sep_pkg::PAGE_BYTES];
  logic [sep_pkg::PAGE_BYTES-1:0] page_vld;
  sep_dev_state_e   state_reg;
  logic [2:0]       bit_cnt_reg;
  logic [7:0]       shift_reg;
  logic [1:0]       byte_idx_reg;
  logic             is_read_reg;
  logic             ack_ok_reg;
  logic             wr_pend_reg;
  logic [AW-1:0]    ptr_reg;
  logic [AW-1:0]    page_base_reg;
  logic [31:0]      busy_cnt_reg;
  logic             sda_low_reg;
  logic [7:0]       rx_byte;
  assign rx_byte = {shift_reg[6:0], sda_s};

  // Byte-level protocol engine
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_reg    <= SEP_IDLE;
      bit_cnt_reg  <= 3'h0;
      shift_reg    <= 8'h00;
      byte_idx_reg <= 2'h0;
      is_read_reg  <= 1'b0;
      ack_ok_reg   <= 1'b0;
    end else if (start_ev) begin
      state_reg    <= SEP_RX;
      bit_cnt_reg  <= 3'h0;
      byte_idx_reg <= 2'h0;
      is_read_reg  <= 1'b0;
    end else if (stop_ev) begin
      state_reg <= SEP_IDLE;
    end else begin
      case (state_reg)
        SEP_RX: begin
          if (scl_rise) begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              state_reg <= SEP_RX_ACK;
              if (byte_idx_reg == 2'h0) begin
                ack_ok_reg  <= (rx_byte[7:4] == sep_pkg::DEV_CODE) &&
                               (rx_byte[3:1] == cs_sync) && (o_busy == 1'b0);
                is_read_reg <= rx_byte[0];
              end else begin
                ack_ok_reg <= ack_ok_reg;
              end
            end
          end
        end
        SEP_RX_ACK: begin
          if (scl_fall && sda_low_reg) begin
            if (!ack_ok_reg) begin
              state_reg <= SEP_IDLE;
            end else if (is_read_reg) begin
              state_reg   <= SEP_TX;
              shift_reg   <= mem[ptr_reg];
              bit_cnt_reg <= 3'h0;
            end else begin
              state_reg <= SEP_RX;
              if (byte_idx_reg != 2'h3) begin
                byte_idx_reg <= byte_idx_reg + 2'h1;
              end
            end
          end else if (scl_fall && !ack_ok_reg) begin
            state_reg <= SEP_IDLE;
          end
        end
        SEP_TX: begin
          if (scl_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg   <= {shift_reg[6:0], 1'b0};
            if (bit_cnt_reg == 3'h7) begin
              state_reg <= SEP_TX_ACK;
            end
          end
        end
        SEP_TX_ACK: begin
          // Next byte starts only at the fall that ends the ack slot
          if (scl_rise && sda_s) begin
            state_reg <= SEP_IDLE;
          end else if (scl_fall) begin
            state_reg   <= SEP_TX;
            shift_reg   <= mem[ptr_reg];
            bit_cnt_reg <= 3'h0;
          end
        end
        default: state_reg <= SEP_IDLE;
      endcase
    end
  end

  // Data line drive: ack or transmitted bit, released otherwise
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      sda_low_reg <= 1'b0;
    end else if (start_ev || stop_ev) begin
      sda_low_reg <= 1'b0;
    end else if (scl_fall) begin
      sda_low_reg <= 1'b0;
      if (state_reg == SEP_RX_ACK && ack_ok_reg && !sda_low_reg) begin
        sda_low_reg <= 1'b1;
      end else if (state_reg == SEP_RX_ACK && sda_low_reg && is_read_reg) begin
        sda_low_reg <= ~mem[ptr_reg][7];
      end else if (state_reg == SEP_TX && bit_cnt_reg != 3'h7) begin
        sda_low_reg <= ~shift_reg[6];
      end else if (state_reg == SEP_TX_ACK) begin
        sda_low_reg <= ~mem[ptr_reg][7];
      end
    end
  end

  assign link.sda_s_o  = 1'b0;
  assign link.sda_s_oe = sda_low_reg;

  // Address pointer, page buffer and commit
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ptr_reg       <= '0;
      page_base_reg <= '0;
      page_vld      <= '0;
      wr_pend_reg   <= 1'b0;
    end else if (stop_ev && wr_pend_reg) begin
      wr_pend_reg <= 1'b0;
      page_vld    <= '0;
      if (!wp_sync[1]) begin
        for (int i = 0; i < sep_pkg::PAGE_BYTES; i++) begin
          if (page_vld[i]) begin
            mem[{page_base_reg[AW-1:PW], PW'(i)}] <= page_buf[i];
          end
        end
      end
    end else if (start_ev) begin
      page_vld    <= '0;
      wr_pend_reg <= 1'b0;
    end else if (state_reg == SEP_RX && scl_rise && bit_cnt_reg == 3'h7 && ack_ok_reg) begin
      case (byte_idx_reg)
        2'h1: ptr_reg[AW-1:8] <= rx_byte[AW-9:0];
        2'h2: begin
          ptr_reg[7:0]  <= rx_byte;
        end
        2'h3: begin
          page_buf[ptr_reg[PW-1:0]] <= rx_byte;
          page_vld[ptr_reg[PW-1:0]] <= 1'b1;
          page_base_reg             <= ptr_reg;
          wr_pend_reg               <= 1'b1;
          ptr_reg[PW-1:0]           <= ptr_reg[PW-1:0] + PW'(1);
        end
        default: ptr_reg <= ptr_reg;
      endcase
    end else if (state_reg == SEP_TX && scl_fall && bit_cnt_reg == 3'h7) begin
      ptr_reg <= ptr_reg + AW'(1);
    end
  end

  // Self-timed write cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      busy_cnt_reg <= 32'h0;
      o_busy       <= 1'b0;
    end else if (stop_ev && wr_pend_reg && !wp_sync[1]) begin
      busy_cnt_reg <= 32'(WRITE_CYC);
      o_busy       <= 1'b1;
    end else if (busy_cnt_reg != 32'h0) begin
      busy_cnt_reg <= busy_cnt_reg - 32'h1;
      o_busy       <= (busy_cnt_reg != 32'h1);
    end
  end
endmodule : sep_dev
`default_nettype wire

// ==== design/sep_mst.sv ====
// Two-wire bus master issuing EEPROM commands from a user request port.
// Assumes the slave shares the link interface; SCL made by a divider.
`timescale 1ns/1ns
`default_nettype none
module sep_mst #(
  parameter int HALF = sep_pkg::LINK_HALF  // Clocks per bit phase, a quarter SCL period
) (
  input  wire logic              i_clk_sys,  // System clock
  input  wire logic              i_rst_n,    // Synchronous reset, active low
  input  wire logic              i_req,      // Start a command, one pulse
  input  wire sep_pkg::sep_cmd_e i_cmd,      // Command kind
  input  wire logic [2:0]        i_cs,       // Target chip select
  input  wire logic [13:0]       i_addr,     // Word address
  input  wire logic [6:0]        i_len,      // Bytes to write or read
  input  wire logic [7:0]        i_wdata,    // Write data, taken on o_wtake
  sep_link_if.mst                link,       // Two-wire link
  output logic                   o_wtake,    // Write byte consumed
  output logic                   o_rvalid,   // Read byte valid pulse
  output logic [7:0]             o_rdata,    // Read byte
  output logic                   o_nack,     // Control, address or data byte unacknowledged
  output logic                   o_done      // Command finished pulse
);
  typedef enum logic [2:0] {
    SEP_M_IDLE, SEP_M_START, SEP_M_BIT, SEP_M_ACK, SEP_M_STOP, SEP_M_FIN
  } sep_mst_state_e;

  sep_mst_state_e state_reg;
  logic [7:0]     div_reg;
  logic [1:0]     ph_reg;
  logic [7:0]     sh_reg;
  logic [2:0]     bit_reg;
  logic [3:0]     step_reg;
  logic [6:0]     left_reg;
  logic           rd_reg;
  logic           scl_reg;
  logic           sda_reg;
  logic           sda_meta;
  logic           sda_in;
  logic           tick;
  sep_pkg::sep_cmd_e cmd_reg;
  logic [2:0]     cs_reg;
  logic [13:0]    addr_reg;
  assign tick = (div_reg == 8'(HALF - 1));

  // Link sample; slave answers are stable by the late phase
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      sda_meta <= 1'b1;
      sda_in   <= 1'b1;
    end else begin
      sda_meta <= link.sda;
      sda_in   <= sda_meta;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= tick ? 8'h00 : div_reg + 8'h01;
    end
  end

  function automatic logic [7:0] ctl(input logic [2:0] cs, input logic rd);
    ctl = {sep_pkg::DEV_CODE, cs, rd};
  endfunction : ctl

  // Phases per bit: 0 low, 1 high, 2 high sample, 3 low
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_reg <= SEP_M_IDLE;
      ph_reg    <= 2'h0;
      sh_reg    <= 8'h00;
      bit_reg   <= 3'h0;
      step_reg  <= 4'h0;
      left_reg  <= 7'h00;
      rd_reg    <= 1'b0;
      scl_reg   <= 1'b1;
      sda_reg   <= 1'b1;
      cmd_reg   <= sep_pkg::SEP_CMD_WRITE;
      cs_reg    <= 3'h0;
      addr_reg  <= 14'h0000;
      o_wtake   <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 8'h00;
      o_nack    <= 1'b0;
      o_done    <= 1'b0;
    end else begin
      o_wtake  <= 1'b0;
      o_rvalid <= 1'b0;
      o_done   <= 1'b0;
      case (state_reg)
        SEP_M_IDLE: if (i_req) begin
          cmd_reg   <= i_cmd;
          cs_reg    <= i_cs;
          addr_reg  <= i_addr;
          left_reg  <= i_len;
          step_reg  <= 4'h0;
          o_nack    <= 1'b0;
          state_reg <= SEP_M_START;
          ph_reg    <= 2'h0;
        end
        SEP_M_START: if (tick) begin
          ph_reg <= ph_reg + 2'h1;
          case (ph_reg)
            2'h0: begin scl_reg <= 1'b1; sda_reg <= 1'b1; end
            2'h1: sda_reg <= 1'b0;
            2'h2: scl_reg <= 1'b0;
            default: begin
              rd_reg  <= (step_reg == 4'h3) ||
                         (cmd_reg == sep_pkg::SEP_CMD_READ_CUR);
              sh_reg  <= ctl(cs_reg, (step_reg == 4'h3) ||
                             (cmd_reg == sep_pkg::SEP_CMD_READ_CUR));
              bit_reg <= 3'h0;
              state_reg <= SEP_M_BIT;
            end
          endcase
        end
        SEP_M_BIT: if (tick) begin
          ph_reg <= ph_reg + 2'h1;
          case (ph_reg)
            2'h0: sda_reg <= (rd_reg && step_reg == 4'h4) ? 1'b1 : sh_reg[7];
            2'h1: scl_reg <= 1'b1;
            2'h2: sh_reg <= {sh_reg[6:0], sda_in};
            default: begin
              scl_reg <= 1'b0;
              bit_reg <= bit_reg + 3'h1;
              if (bit_reg == 3'h7) state_reg <= SEP_M_ACK;
            end
          endcase
        end
        SEP_M_ACK: if (tick) begin
          ph_reg <= ph_reg + 2'h1;
          case (ph_reg)
            2'h0: sda_reg <= !(step_reg == 4'h4 && left_reg > 7'h1);
            2'h1: scl_reg <= 1'b1;
            2'h2: if (step_reg != 4'h4 && sda_in) o_nack <= 1'b1;
            default: begin
              scl_reg <= 1'b0;
              bit_reg <= 3'h0;
              state_reg <= SEP_M_BIT;
              if (o_nack || cmd_reg == sep_pkg::SEP_CMD_POLL) begin
                state_reg <= SEP_M_STOP;
              end else if (step_reg == 4'h4) begin
                o_rvalid <= 1'b1;
                o_rdata  <= sh_reg;
                left_reg <= left_reg - 7'h1;
                if (left_reg <= 7'h1) state_reg <= SEP_M_STOP;
              end else if (rd_reg) begin
                step_reg <= 4'h4;
                sh_reg   <= 8'hff;
              end else if (step_reg == 4'h0) begin
                step_reg <= 4'h1;
                sh_reg   <= {2'h0, addr_reg[13:8]};
              end else if (step_reg == 4'h1) begin
                step_reg <= 4'h2;
                sh_reg   <= addr_reg[7:0];
              end else if (cmd_reg == sep_pkg::SEP_CMD_READ_RAND) begin
                step_reg  <= 4'h3;
                ph_reg    <= 2'h0;
                state_reg <= SEP_M_START;
              end else if (left_reg == 7'h0) begin
                state_reg <= SEP_M_STOP;
              end else begin
                sh_reg   <= i_wdata;
                o_wtake  <= 1'b1;
                left_reg <= left_reg - 7'h1;
                step_reg <= 4'h5;
              end
            end
          endcase
        end
        SEP_M_STOP: if (tick) begin
          ph_reg <= ph_reg + 2'h1;
          case (ph_reg)
            2'h0: sda_reg <= 1'b0;
            2'h1: scl_reg <= 1'b1;
            2'h2: sda_reg <= 1'b1;
            default: state_reg <= SEP_M_FIN;
          endcase
        end
        SEP_M_FIN: begin
          o_done    <= 1'b1;
          state_reg <= SEP_M_IDLE;
        end
        default: state_reg <= SEP_M_IDLE;
      endcase
    end
  end

  assign link.scl_o    = 1'b0;
  assign link.scl_oe   = ~scl_reg;
  assign link.sda_m_o  = 1'b0;
  assign link.sda_m_oe = ~sda_reg;
endmodule : sep_mst
`default_nettype wire

// ==== bench/sep_sva.sv ====
// Link checker for the EEPROM slave and master, watching the shared lines.
// Assumes the master default HALF of 8 clocks per bit phase, 16 per SCL half period.
`timescale 1ns/1ns
`default_nettype none
module sep_sva (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst_n,   // Reset, active low
  input wire logic scl_o,     // Master clock value
  input wire logic scl_oe,    // Master clock pull
  input wire logic sda_m_o,   // Master data value
  input wire logic sda_m_oe,  // Master data pull
  input wire logic sda_s_o,   // Slave data value
  input wire logic sda_s_oe,  // Slave data pull
  input wire logic scl,       // Resolved clock
  input wire logic sda        // Resolved data
);
  logic [15:0] lo_cnt_reg;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Length of the current slave pull-low run
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || !sda_s_oe) begin
      lo_cnt_reg <= 16'h0000;
    end else begin
      lo_cnt_reg <= lo_cnt_reg + 16'h0001;
    end
  end
  a_slave_od_low: assert property (sda_s_oe |-> !sda_s_o)
    else $error("slave drives data high");
  a_mst_od_low: assert property ((scl_oe |-> !scl_o) and (sda_m_oe |-> !sda_m_o))
    else $error("master drives a line high");
  a_slave_stable_high: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("slave data changed while clock high");
  a_slave_no_start: assert property (scl && $fell(sda) |-> !sda_s_oe)
    else $error("slave took part in a start");
  a_stop_released: assert property (scl && $rose(sda) |->
    !sda_s_oe && !$past(sda_s_oe))
    else $error("slave held data at stop");
  a_scl_low_len: assert property ($rose(scl_oe) |-> scl_oe [*8])
    else $error("clock low phase too short");
  a_scl_high_len: assert property ($fell(scl_oe) |-> !scl_oe [*8])
    else $error("clock high phase too short");
  a_slave_low_bound: assert property (lo_cnt_reg < 16'd400)
    else $error("slave holds data low too long");
  // Slave data moves only a fixed sync delay after a clock fall
  a_slave_fall_timed: assert property ($changed(sda_s_oe) |->
    $past(scl, 4) && !$past(scl, 3))
    else $error("slave data changed away from a clock fall");
  c_start: cover property (scl && $fell(sda));
  c_stop: cover property (scl && $rose(sda));
  c_slave_ack: cover property (scl && sda_s_oe && !sda_m_oe);
endmodule : sep_sva
`default_nettype wire

// ==== bench/testbench.sv ====
// Bench joining the EEPROM slave and master over one link.
// Assumes the master drives SCL itself; write cycle shortened to 1000.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic              i_clk_sys = 1'b0;
  logic              i_rst_n   = 1'b0;
  logic              i_wp      = 1'b0;
  logic [2:0]        i_chip_select_inputs = 3'h2;
  logic              i_req     = 1'b0;
  sep_pkg::sep_cmd_e i_cmd     = sep_pkg::SEP_CMD_POLL;
  logic [2:0]        i_cs      = 3'h2;
  logic [13:0]       i_addr    = 14'h0000;
  logic [6:0]        i_len     = 7'h01;
  logic [7:0]        i_wdata   = 8'h00;
  logic              o_busy;
  logic              o_wtake;
  logic              o_rvalid;
  logic              o_nack;
  logic              o_done;
  logic [7:0]        o_rdata;
  logic [7:0]        em [0:16383];
  logic [7:0]        wbuf [0:127];
  logic [7:0]        rq [$];
  int                error_cnt = 0;
  int                n_tests   = 0;
  int                nacks;
  always #4 i_clk_sys = ~i_clk_sys;
  sep_link_if link ();
  sep_dev #(.WRITE_CYC(1000)) u_sep_dev (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_chip_select_inputs(i_chip_select_inputs), .i_wp(i_wp), .link(link), .o_busy(o_busy));
  sep_mst u_sep_mst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(i_req),
    .i_cmd(i_cmd), .i_cs(i_cs), .i_addr(i_addr), .i_len(i_len), .i_wdata(i_wdata),
    .link(link), .o_wtake(o_wtake), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
    .o_nack(o_nack), .o_done(o_done));
  sep_sva u_sep_sva (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .scl_o(link.scl_o),
    .scl_oe(link.scl_oe), .sda_m_o(link.sda_m_o), .sda_m_oe(link.sda_m_oe),
    .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda));
  task automatic close_out();
    $display("Compares %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: flag %h expected %h", $time, got, exp);
    end
  endtask : chk_flag
  // One user command, feeding write bytes and gathering read bytes
  task automatic run(input sep_pkg::sep_cmd_e c, input logic [2:0] cs,
                     input logic [13:0] a, input logic [6:0] n);
    int widx;
    int k;
    widx = 0;
    rq.delete();
    i_cmd <= c;
    i_cs <= cs;
    i_addr <= a;
    i_len <= n;
    i_wdata <= wbuf[0];
    i_req <= 1'b1;
    @(posedge i_clk_sys);
    i_req <= 1'b0;
    for (k = 0; k < 40000; k++) begin
      @(posedge i_clk_sys);
      if (o_wtake === 1'b1) begin
        widx++;
        i_wdata <= wbuf[widx];
      end
      if (o_rvalid === 1'b1) begin
        rq.push_back(o_rdata);
      end
      if (o_done === 1'b1) begin
        break;
      end
    end
    if (k == 40000) begin
      error_cnt++;
      $display("Error at %0t: done %h expected %h", $time, 1'b0, 1'b1);
      close_out();
    end
    @(posedge i_clk_sys);
  endtask : run
  task automatic wr(input logic [13:0] a, input logic [6:0] n, input logic [7:0] b,
                    input logic st);
    int i;
    logic [5:0] lo;
    for (i = 0; i < n; i++) begin
      wbuf[i] = b + 8'(i);
      lo = a[5:0] + 6'(i);
      if (st) begin
        em[{a[13:6], lo}] = wbuf[i];
      end
    end
    run(sep_pkg::SEP_CMD_WRITE, 3'h2, a, n);
  endtask : wr
  task automatic rd(input sep_pkg::sep_cmd_e c, input logic [13:0] a, input logic [6:0] n,
                    input logic [13:0] ea);
    int i;
    logic [13:0] ix;
    run(c, 3'h2, a, n);
    chk_flag(rq.size() == int'(n), 1'b1);
    for (i = 0; i < n; i++) begin
      ix = ea + 14'(i);
      chk_byte(rq[i], em[ix]);
    end
  endtask : rd
  task automatic poll_ready();
    int p;
    nacks = 0;
    for (p = 0; p < 20; p++) begin
      run(sep_pkg::SEP_CMD_POLL, 3'h2, 14'h0000, 7'h01);
      if (o_nack === 1'b0) begin
        break;
      end
      nacks++;
    end
    if (p == 20) begin
      error_cnt++;
      $display("Error at %0t: nack %h expected %h", $time, 1'b1, 1'b0);
      close_out();
    end
  endtask : poll_ready
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    // Page write past the page end, then ack polling
    wr(14'h003c, 7'd66, 8'h11, 1'b1);
    chk_flag(o_busy, 1'b1);
    poll_ready();
    chk_flag(nacks > 0, 1'b1);
    chk_flag(o_nack, 1'b0);
    $display("Test page_write done");
    rd(sep_pkg::SEP_CMD_READ_RAND, 14'h0000, 7'd63, 14'h0000);
    rd(sep_pkg::SEP_CMD_READ_CUR, 14'h0000, 7'd1, 14'h003f);
    $display("Test reads done");
    // Protected write: acked, nothing stored, ready at once
    i_wp <= 1'b1;
    wr(14'h0010, 7'd2, 8'h80, 1'b0);
    i_wp <= 1'b0;
    chk_flag(o_nack, 1'b0);
    chk_flag(o_busy, 1'b0);
    run(sep_pkg::SEP_CMD_POLL, 3'h2, 14'h0000, 7'h01);
    chk_flag(o_nack, 1'b0);
    rd(sep_pkg::SEP_CMD_READ_RAND, 14'h0010, 7'd2, 14'h0010);
    $display("Test protect done");
    // Protect raised after Stop, then read across the top
    wr(14'h3fff, 7'd1, 8'h5a, 1'b1);
    i_wp <= 1'b1;
    chk_flag(o_busy, 1'b1);
    poll_ready();
    i_wp <= 1'b0;
    rd(sep_pkg::SEP_CMD_READ_RAND, 14'h3fff, 7'd2, 14'h3fff);
    $display("Test wrap done");
    run(sep_pkg::SEP_CMD_POLL, 3'h5, 14'h0000, 7'h01);
    chk_flag(o_nack, 1'b1);
    i_chip_select_inputs <= 3'h5;
    run(sep_pkg::SEP_CMD_POLL, 3'h5, 14'h0000, 7'h01);
    chk_flag(o_nack, 1'b0);
    $display("Test select done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
